/* File: include/freq_bank_pkg.sv */
// Package for the frequency element bank: register map, field layout,
// reset values, setting limits and the carrier structs.
// Assumes a 32-bit AXI4-Lite register bus and a same-clock measurement front end.
package freq_bank_pkg;

    localparam int          NUM_ELEM     = 6;
    localparam int          ADDR_W       = 8;

    // Register byte offsets
    localparam logic [7:0]  OFF_CTRL     = 8'h00;
    localparam logic [7:0]  OFF_UV_PICK  = 8'h04;
    localparam logic [7:0]  OFF_STATUS   = 8'h08;
    localparam logic [7:0]  OFF_IRQ_STAT = 8'h0C;
    localparam logic [7:0]  OFF_IRQ_EN   = 8'h10;
    localparam logic [7:0]  OFF_IRQ_CLR  = 8'h14;
    localparam logic [7:0]  OFF_ELEM     = 8'h20;
    localparam logic [7:0]  ELEM_STRIDE  = 8'h08;
    localparam logic [7:0]  OFF_ELEM_END = 8'h50;
    localparam int          ELEM_SHIFT   = 3;
    localparam int          ELEM_SEL_BIT = 2;

    // Control fields
    localparam int          CTRL_CNT_LSB = 0;
    localparam int          CTRL_NOM_BIT = 3;
    localparam logic [2:0]  CNT_RST      = 3'h0;
    localparam logic [2:0]  CNT_MAX      = 3'h6;

    // Status fields
    localparam int          ST_INST_LSB  = 0;
    localparam int          ST_TIMED_LSB = 8;
    localparam int          ST_UV_BIT    = 16;
    localparam int          IRQ_UV_BIT   = 6;
    localparam int          IRQ_W        = 7;

    // Frequency in 0.01 Hz, voltage in 1 V, delay in quarter cycles
    localparam logic [15:0] NOM_60_CHZ   = 16'h1770;
    localparam logic [15:0] NOM_50_CHZ   = 16'h1388;
    localparam logic [15:0] PICK_OFF     = 16'h0000;
    localparam logic [15:0] PICK_MIN_CHZ = 16'h0FAA;
    localparam logic [15:0] PICK_MAX_CHZ = 16'h1B4E;
    localparam logic [15:0] UV_MIN_V     = 16'h0037;
    localparam logic [15:0] UV_MAX_V     = 16'h0190;
    localparam logic [15:0] DLY_MIN_QC   = 16'h0014;
    localparam logic [15:0] DLY_MAX_QC   = 16'hFA00;

    localparam logic [1:0]  RESP_OKAY    = 2'h0;
    localparam logic [1:0]  RESP_SLVERR  = 2'h2;

    typedef struct packed {
        logic [15:0] freq_va_chz;
        logic [15:0] volt_va;
        logic        qcyc_tick;
    } meas_t;

    typedef struct packed {
        logic [NUM_ELEM-1:0] inst;
        logic [NUM_ELEM-1:0] timed;
        logic                uv_block;
    } flags_t;

endpackage

/* File: hw/frequency_element_bank.sv */
// Frequency element bank: six over/under frequency elements with delay
// timers, an undervoltage block, AXI4-Lite settings and an interrupt.
// Assumes meas comes from same-clock logic and qcyc_tick pulses once per
// quarter power-system cycle.
`timescale 1ns/10ps
module frequency_element_bank
    import freq_bank_pkg::*;
(
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              arst_n,
    // Measurement front end
    input  wire meas_t             meas,
    // Status to control logic
    output flags_t                 flags,
    output logic                   irq,
    // AXI4-Lite write
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    // AXI4-Lite read
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready
);

    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    logic [2:0]          cnt_q;
    logic                nom50_q;
    logic [15:0]         uv_pick_q;
    logic [15:0]         pick_q [NUM_ELEM];
    logic [15:0]         dly_q  [NUM_ELEM];
    logic [15:0]         tmr_q  [NUM_ELEM];
    logic [NUM_ELEM-1:0] inst_q;
    logic [NUM_ELEM-1:0] timed_q;
    logic                uv_q;
    logic [IRQ_W-1:0]    irq_stat_q;
    logic [IRQ_W-1:0]    irq_en_q;
    logic                irq_q;
    logic [15:0]         nominal;
    logic                uv_cond;
    logic [NUM_ELEM-1:0] inst_d;
    logic [NUM_ELEM-1:0] timed_d;

    // Write channel holding
    logic [ADDR_W-1:0]   awaddr_q;
    logic                aw_held_q;
    logic [31:0]         wdata_q;
    logic [3:0]          wstrb_q;
    logic                w_held_q;
    logic                bvalid_q;
    logic [1:0]          bresp_q;
    logic                rvalid_q;
    logic [31:0]         rdata_q;
    logic [1:0]          rresp_q;
    logic                wr_fire;
    logic                wr_ok;
    logic [31:0]         rd_val;
    logic                rd_ok;
    logic [15:0]         wr16;
    logic [31:0]         wr_old;
    logic [31:0]         wr_new;
    logic [2:0]          wr_idx;
    logic [2:0]          rd_idx;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                r[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
        return r;
    endfunction

    assign nominal = nom50_q ? NOM_50_CHZ : NOM_60_CHZ;
    assign uv_cond = (uv_pick_q != PICK_OFF) && (meas.volt_va < uv_pick_q);

    // Per-element compare and timer
    generate
        for (genvar i = 0; i < NUM_ELEM; i++) begin : g_elem
            logic active;
            logic over;
            logic cond;
            assign active = (3'(i) < cnt_q) && (pick_q[i] != PICK_OFF);
            assign over   = pick_q[i] >= nominal;
            // Phase A frequency is the only measured input
            assign cond   = over ? (meas.freq_va_chz > pick_q[i])
                                 : (meas.freq_va_chz <= pick_q[i]);
            assign inst_d[i] = active && !uv_cond && cond;
            assign timed_d[i] = inst_d[i] && (tmr_q[i] >= dly_q[i]);

            always_ff @(posedge clk or negedge arst_n) begin
                if (!arst_n) begin
                    tmr_q[i] <= 16'h0000;
                end else if (!inst_d[i]) begin
                    tmr_q[i] <= 16'h0000;
                end else if (meas.qcyc_tick && tmr_q[i] < dly_q[i]) begin
                    tmr_q[i] <= tmr_q[i] + 16'h0001;
                end
            end

            always_ff @(posedge clk or negedge arst_n) begin
                if (!arst_n) begin
                    inst_q[i]  <= 1'b0;
                    timed_q[i] <= 1'b0;
                end else begin
                    inst_q[i]  <= inst_d[i];
                    timed_q[i] <= timed_d[i];
                end
            end

            a_inst_count: assert property (inst_q[i] |-> $past(3'(i) < cnt_q))
                else $error("element flagged beyond enable count");
            a_over_pick: assert property ($past(active && !uv_cond && over
                && meas.freq_va_chz > pick_q[i]) |-> inst_q[i])
                else $error("overfrequency flag missing");
            a_under_pick: assert property ($past(!over) && $past(active && !uv_cond)
                |-> inst_q[i] == $past(meas.freq_va_chz <= pick_q[i]))
                else $error("underfrequency flag wrong");
            a_uv_blocks: assert property ($past(uv_cond) |-> !inst_q[i] && tmr_q[i] == 16'h0000)
                else $error("undervoltage did not block element");
            a_timed_drop: assert property (timed_q[i] |-> inst_q[i])
                else $error("timed flag without instantaneous flag");
            a_timed_after: assert property ($rose(timed_q[i]) |-> $past(tmr_q[i] >= dly_q[i]
                && dly_q[i] >= DLY_MIN_QC))
                else $error("timed flag before delay elapsed");
            a_off_clear: assert property ($past(pick_q[i] == PICK_OFF) |-> !timed_q[i]
                && !inst_q[i] && tmr_q[i] == 16'h0000)
                else $error("OFF element not cleared");
            a_pick_range: assert property (pick_q[i] == PICK_OFF
                || (pick_q[i] >= PICK_MIN_CHZ && pick_q[i] <= PICK_MAX_CHZ))
                else $error("pickup outside range");
            a_dly_range: assert property (dly_q[i] >= DLY_MIN_QC && dly_q[i] <= DLY_MAX_QC)
                else $error("delay outside range");
        end
    endgenerate

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            uv_q <= 1'b0;
        end else begin
            uv_q <= uv_cond;
        end
    end

    a_uv_flag: assert property (flags.uv_block == $past(uv_cond))
        else $error("undervoltage flag does not follow voltage");

    assign flags = '{inst: inst_q, timed: timed_q, uv_block: uv_q};

    // Interrupt: set wins over a clear in the same cycle
    logic [IRQ_W-1:0] irq_ev;
    logic [IRQ_W-1:0] irq_clr;
    // Events are rising edges only, so a standing flag cannot refill status
    assign irq_ev  = {uv_cond && !uv_q, timed_d & ~timed_q};
    assign irq_clr = (wr_fire && awaddr_q == OFF_IRQ_CLR) ? wr_new[IRQ_W-1:0] : '0;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            irq_stat_q <= '0;
            irq_q      <= 1'b0;
        end else begin
            irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_ev;
            irq_q      <= |(irq_stat_q & irq_en_q);
        end
    end
    assign irq = irq_q;

    a_irq_sticky: assert property ($rose(timed_q[0]) |-> irq_stat_q[0])
        else $error("timed event not captured");

    // Register writes, ranges checked before the value is taken
    assign wr_fire = aw_held_q && w_held_q && !bvalid_q;
    assign wr_idx  = 3'((awaddr_q - OFF_ELEM) >> ELEM_SHIFT);
    always_comb begin
        wr_old = 32'h0;
        wr_ok  = 1'b1;
        if (awaddr_q == OFF_CTRL) begin
            wr_old = {28'h0, nom50_q, cnt_q};
        end else if (awaddr_q == OFF_UV_PICK) begin
            wr_old = {16'h0, uv_pick_q};
        end else if (awaddr_q == OFF_IRQ_EN) begin
            wr_old = {25'h0, irq_en_q};
        end else if (awaddr_q == OFF_IRQ_CLR || awaddr_q == OFF_STATUS
                     || awaddr_q == OFF_IRQ_STAT) begin
            wr_old = 32'h0;
        end else if (awaddr_q >= OFF_ELEM && awaddr_q < OFF_ELEM_END
                     && awaddr_q[1:0] == 2'h0) begin
            wr_old = {16'h0, awaddr_q[ELEM_SEL_BIT] ? dly_q[wr_idx] : pick_q[wr_idx]};
        end else begin
            wr_ok = 1'b0;
        end
    end
    // Clear register merges onto zero, so wr_new is also the clear mask
    assign wr_new = merge(wr_old, wdata_q, wstrb_q);
    assign wr16   = wr_new[15:0];

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_q     <= CNT_RST;
            nom50_q   <= 1'b0;
            uv_pick_q <= PICK_OFF;
            irq_en_q  <= '0;
            for (int k = 0; k < NUM_ELEM; k++) begin
                pick_q[k] <= PICK_OFF;
                dly_q[k]  <= DLY_MIN_QC;
            end
        end else if (wr_fire && wr_ok) begin
            if (awaddr_q == OFF_CTRL) begin
                nom50_q <= wr16[CTRL_NOM_BIT];
                if (wr16[CTRL_CNT_LSB +: 3] <= CNT_MAX) begin
                    cnt_q <= wr16[CTRL_CNT_LSB +: 3];
                end
            end else if (awaddr_q == OFF_UV_PICK) begin
                if (wr16 == PICK_OFF || (wr16 >= UV_MIN_V && wr16 <= UV_MAX_V)) begin
                    uv_pick_q <= wr16;
                end
            end else if (awaddr_q == OFF_IRQ_EN) begin
                irq_en_q <= wr16[IRQ_W-1:0];
            end else if (awaddr_q >= OFF_ELEM && awaddr_q < OFF_ELEM_END) begin
                if (awaddr_q[ELEM_SEL_BIT]) begin
                    if (wr16 >= DLY_MIN_QC && wr16 <= DLY_MAX_QC) begin
                        dly_q[wr_idx] <= wr16;
                    end
                end else if (wr16 == PICK_OFF
                             || (wr16 >= PICK_MIN_CHZ && wr16 <= PICK_MAX_CHZ)) begin
                    pick_q[wr_idx] <= wr16;
                end
            end
        end
    end

    // Write channel: address and data taken in either order
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            aw_held_q <= 1'b0;
            w_held_q  <= 1'b0;
            awaddr_q  <= '0;
            wdata_q   <= 32'h0;
            wstrb_q   <= 4'h0;
            bvalid_q  <= 1'b0;
            bresp_q   <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_q <= 1'b1;
                awaddr_q  <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_q <= 1'b1;
                wdata_q  <= s_axi_wdata;
                wstrb_q  <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_held_q <= 1'b0;
                w_held_q  <= 1'b0;
                bvalid_q  <= 1'b1;
                bresp_q   <= wr_ok ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end
    assign s_axi_awready = !aw_held_q && !bvalid_q;
    assign s_axi_wready  = !w_held_q && !bvalid_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;

    // Read channel; a read never disturbs sticky state
    assign rd_idx = 3'((s_axi_araddr - OFF_ELEM) >> ELEM_SHIFT);
    always_comb begin
        rd_val = 32'h0;
        rd_ok  = 1'b1;
        if (s_axi_araddr == OFF_CTRL) begin
            rd_val = {28'h0, nom50_q, cnt_q};
        end else if (s_axi_araddr == OFF_UV_PICK) begin
            rd_val = {16'h0, uv_pick_q};
        end else if (s_axi_araddr == OFF_STATUS) begin
            rd_val[ST_INST_LSB +: NUM_ELEM]  = inst_q;
            rd_val[ST_TIMED_LSB +: NUM_ELEM] = timed_q;
            rd_val[ST_UV_BIT]                = uv_q;
        end else if (s_axi_araddr == OFF_IRQ_STAT) begin
            rd_val = {25'h0, irq_stat_q};
        end else if (s_axi_araddr == OFF_IRQ_EN) begin
            rd_val = {25'h0, irq_en_q};
        end else if (s_axi_araddr == OFF_IRQ_CLR) begin
            rd_val = 32'h0;
        end else if (s_axi_araddr >= OFF_ELEM && s_axi_araddr < OFF_ELEM_END
                     && s_axi_araddr[1:0] == 2'h0) begin
            rd_val = {16'h0, s_axi_araddr[ELEM_SEL_BIT] ? dly_q[rd_idx] : pick_q[rd_idx]};
        end else begin
            rd_ok = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h0;
            rresp_q  <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_q <= 1'b1;
            rdata_q  <= rd_val;
            rresp_q  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end
    assign s_axi_arready = !rvalid_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rdata   = rdata_q;
    assign s_axi_rresp   = rresp_q;

endmodule // frequency_element_bank

/* File: sim/meas_source.sv */
// Measurement front end model: phase-A frequency, voltage and quarter-cycle tick.
// Assumes the bench sets frequency and voltage levels on the same clock.
`timescale 1ns/10ps
module meas_source
    import freq_bank_pkg::*;
#(
    parameter int TICK_DIV = 4
)
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        arst_n,
    // Phase-A levels from the bench
    input  wire logic [15:0] freq_chz,
    input  wire logic [15:0] volt_v,
    // Measurement bundle
    output meas_t            meas
);
    logic [7:0] div_q;

    // Short tick period keeps delay tests fast
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            div_q <= 8'h00;
        end else begin
            div_q <= (div_q == 8'(TICK_DIV - 1)) ? 8'h00 : div_q + 8'h01;
        end
    end

    assign meas.freq_va_chz = freq_chz;
    assign meas.volt_va     = volt_v;
    assign meas.qcyc_tick   = (div_q == 8'(TICK_DIV - 1));
endmodule // meas_source

/* File: sim/tb.sv */
// Self-checking bench for the frequency element bank.
// Assumes the AXI4-Lite slave and meas_source model on one 25 MHz clock.
`timescale 1ns/10ps
module tb;
    import freq_bank_pkg::*;
    logic              clk = 1'b0;
    logic              arst_n = 1'b0;
    logic [15:0]       freq_chz = 16'h1770;
    logic [15:0]       volt_v = 16'h0078;
    meas_t             meas;
    flags_t            flags;
    logic              irq;
    logic [7:0]        s_axi_awaddr = 8'h00;
    logic [7:0]        s_axi_araddr = 8'h00;
    logic              s_axi_awvalid = 1'b0;
    logic              s_axi_wvalid = 1'b0;
    logic              s_axi_bready = 1'b0;
    logic              s_axi_arvalid = 1'b0;
    logic              s_axi_rready = 1'b0;
    logic [31:0]       s_axi_wdata = 32'h0;
    logic [3:0]        s_axi_wstrb = 4'hF;
    logic              s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]        s_axi_bresp, s_axi_rresp;
    logic [31:0]       s_axi_rdata;
    logic [33:0]       exp_q[$];
    int                errors = 0;
    int                tests_run = 0;
    logic [2:0]        cnt = 3'h0;
    logic              nom50 = 1'b0;
    logic [15:0]       uvp = 16'h0;
    logic [15:0]       pick [NUM_ELEM] = '{default: 16'h0};

    always #20 clk = ~clk;

    meas_source #(.TICK_DIV(4)) u_src (.clk, .arst_n, .freq_chz, .volt_v, .meas);

    frequency_element_bank u_dut (.clk, .arst_n, .meas, .flags, .irq,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready);

    task automatic check(input logic [33:0] seen, input logic [33:0] exp);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Watcher: every bus answer takes the oldest note
    always @(posedge clk) begin
        if (s_axi_rvalid && s_axi_rready) begin
            check({s_axi_rresp, s_axi_rdata}, exp_q.pop_front());
        end else if (s_axi_bvalid && s_axi_bready) begin
            check({s_axi_bresp, 32'h0}, exp_q.pop_front());
        end
    end

    function automatic logic [33:0] ok(input logic [31:0] d);
        return {RESP_OKAY, d};
    endfunction

    function automatic logic [33:0] fx(input logic [31:0] s);
        return {21'h0, s[5:0], s[13:8], s[16]};
    endfunction

    function automatic logic [7:0] ea(input int i);
        return OFF_ELEM + ELEM_STRIDE * 8'(i);
    endfunction

    function automatic logic [31:0] st(input logic timed_on);
        logic [15:0] nom;
        logic        uv;
        logic [5:0]  in;
        nom = nom50 ? NOM_50_CHZ : NOM_60_CHZ;
        uv = (uvp != 16'h0) && (volt_v < uvp);
        in = 6'h0;
        for (int i = 0; i < NUM_ELEM; i++) begin
            if (i < int'(cnt) && pick[i] != PICK_OFF && !uv) begin
                in[i] = (pick[i] >= nom) ? (freq_chz > pick[i]) : (freq_chz <= pick[i]);
            end
        end
        return {15'h0, uv, 2'h0, timed_on ? in : 6'h0, 2'h0, in};
    endfunction

    task automatic tmo();
        errors++;
        give_verdict();
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        int   n;
        logic got;
        exp_q.push_back({r, 32'h0});
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        n = 0;
        got = 1'b0;
        while (!got && n < 50) begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            got = s_axi_bvalid;
            n++;
        end
        s_axi_bready <= 1'b0;
        if (!got) tmo();
    endtask

    task automatic rd(input logic [7:0] a, input logic [33:0] e);
        int   n;
        logic got;
        exp_q.push_back(e);
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        n = 0;
        got = 1'b0;
        while (!got && n < 50) begin
            @(posedge clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            got = s_axi_rvalid;
            n++;
        end
        s_axi_rready <= 1'b0;
        if (!got) tmo();
    endtask

    task automatic setp(input int i, input logic [15:0] v);
        wr(ea(i), {16'h0, v}, RESP_OKAY);
        pick[i] = v;
    endtask

    task automatic setf(input logic [15:0] f);
        @(posedge clk);
        freq_chz <= f;
    endtask

    task automatic setv(input logic [15:0] v);
        @(posedge clk);
        volt_v <= v;
    endtask

    // Over 25 ticks, beyond the 20-tick default delay
    task automatic settle();
        repeat (100) @(posedge clk);
    endtask

    task automatic done_test(input string name);
        $display("test %s done, mismatches so far %0d", name, errors);
    endtask

    initial begin
        automatic logic [15:0] ftab [5] = '{16'h17ED, 16'h17EE, 16'h174D, 16'h174E, 16'h1770};
        void'($urandom(32'h951F9D04));
        repeat (3) @(posedge clk);
        arst_n <= 1'b1;
        rd(OFF_CTRL, ok(32'h0));
        rd(OFF_UV_PICK, ok(32'h0));
        for (int i = 0; i < NUM_ELEM; i++) begin
            rd(ea(i), ok(32'h0));
            rd(ea(i) + 8'h04, ok(32'h14));
        end
        rd(OFF_STATUS, ok(32'h0));
        rd(OFF_IRQ_STAT, ok(32'h0));
        rd(8'h18, {RESP_SLVERR, 32'h0});
        wr(8'h1C, 32'h1, RESP_SLVERR);
        done_test("reset");
        wr(OFF_CTRL, 32'h2, RESP_OKAY);
        cnt = 3'h2;
        setp(0, 16'h17ED);
        setp(1, 16'h174D);
        foreach (ftab[k]) begin
            setf(ftab[k]);
            settle();
            rd(OFF_STATUS, ok(st(1'b1)));
            check({21'h0, flags}, fx(st(1'b1)));
        end
        done_test("boundaries");
        setf(16'h17EE);
        repeat (60) @(posedge clk);
        rd(OFF_STATUS, ok(st(1'b0)));
        repeat (40) @(posedge clk);
        rd(OFF_STATUS, ok(st(1'b1)));
        setf(16'h1770);
        wr(OFF_UV_PICK, 32'h64, RESP_OKAY);
        uvp = 16'h0064;
        setf(16'h17EE);
        repeat (50) @(posedge clk);
        setv(16'h0063);
        repeat (8) @(posedge clk);
        rd(OFF_STATUS, ok(st(1'b0)));
        check({21'h0, flags}, fx(st(1'b0)));
        setv(16'h0078);
        repeat (50) @(posedge clk);
        rd(OFF_STATUS, ok(st(1'b0)));
        done_test("timer");
        wr(ea(0), 32'h0FA9, RESP_OKAY);
        rd(ea(0), ok(32'h17ED));
        wr(ea(0) + 8'h04, 32'h13, RESP_OKAY);
        rd(ea(0) + 8'h04, ok(32'h14));
        wr(ea(5) + 8'h04, {16'h0, DLY_MAX_QC}, RESP_OKAY);
        rd(ea(5) + 8'h04, ok({16'h0, DLY_MAX_QC}));
        wr(OFF_UV_PICK, 32'h36, RESP_OKAY);
        rd(OFF_UV_PICK, ok(32'h64));
        done_test("ranges");
        setp(2, 16'h1838);
        setp(3, PICK_MAX_CHZ);
        setp(4, NOM_60_CHZ);
        setf(16'h189C);
        for (int c = 0; c <= 6; c++) begin
            wr(OFF_CTRL, 32'(c), RESP_OKAY);
            cnt = 3'(c);
            settle();
            rd(OFF_STATUS, ok(st(1'b1)));
            check({21'h0, flags}, fx(st(1'b1)));
        end
        wr(OFF_CTRL, 32'h7, RESP_OKAY);
        rd(OFF_CTRL, ok(32'h6));
        done_test("count");
        for (int k = 0; k < 12; k++) begin
            nom50 = k[0];
            wr(OFF_CTRL, {28'h0, nom50, 3'h6}, RESP_OKAY);
            setf(16'(4010 + $urandom % 2981));
            settle();
            rd(OFF_STATUS, ok(st(1'b1)));
        end
        done_test("random");
        nom50 = 1'b0;
        wr(OFF_CTRL, 32'h6, RESP_OKAY);
        setf(16'h1770);
        settle();
        wr(OFF_IRQ_CLR, 32'h7F, RESP_OKAY);
        rd(OFF_IRQ_STAT, ok(32'h0));
        setf(16'h17EE);
        settle();
        rd(OFF_IRQ_STAT, ok(32'h11));
        check({33'h0, irq}, 34'h0);
        wr(OFF_IRQ_EN, 32'h1, RESP_OKAY);
        repeat (2) @(posedge clk);
        check({33'h0, irq}, 34'h1);
        wr(OFF_IRQ_CLR, 32'h1, RESP_OKAY);
        rd(OFF_IRQ_STAT, ok(32'h10));
        check({33'h0, irq}, 34'h0);
        rd(OFF_IRQ_CLR, ok(32'h0));
        wr(OFF_IRQ_EN, 32'h40, RESP_OKAY);
        setv(16'h0063);
        repeat (3) @(posedge clk);
        check({33'h0, irq}, 34'h1);
        rd(OFF_STATUS, ok(st(1'b0)));
        done_test("interrupt");
        give_verdict();
    end
endmodule // tb
